// ===== cet_pkg.sv
// Constants and types shared by the core exception and timing controller
package cet_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] CET_OFS_SW = 8'h00;
  localparam logic [7:0] CET_OFS_VBR = 8'h04;
  localparam logic [7:0] CET_OFS_MCTL = 8'h08;
  localparam logic [7:0] CET_OFS_STATE = 8'h0c;
  localparam logic [7:0] CET_OFS_SP = 8'h10;
  localparam logic [7:0] CET_OFS_PC = 8'h14;
  // Status word fields and reset values
  localparam int CET_SW_T = 15;
  localparam int CET_SW_S = 13;
  localparam int CET_SW_M = 12;
  localparam int CET_SW_MASK_LO = 8;
  localparam logic [15:0] CET_SW_RST = 16'h2700;
  localparam logic [2:0] CET_MASK_TOP = 3'h7;
  localparam logic [31:0] CET_VBR_RST = 32'h0000_0000;
  // Reset fetch addresses
  localparam logic [31:0] CET_ADR_SP = 32'h0000_0000;
  localparam logic [31:0] CET_ADR_PC = 32'h0000_0004;
  // Vector numbers
  localparam logic [7:0] CET_VEC_RST = 8'h00;
  localparam logic [7:0] CET_VEC_ACC = 8'h02;
  localparam logic [7:0] CET_VEC_ADR = 8'h03;
  localparam logic [7:0] CET_VEC_SPUR = 8'h18;
  localparam logic [7:0] CET_VEC_TRAP = 8'h20;
  // Store resource busy window in cycles
  localparam logic [1:0] CET_STORE_BUSY = 2'h2;
  // Operand sizes
  localparam logic [1:0] CET_SZ_BYTE = 2'h0;
  localparam logic [1:0] CET_SZ_WORD = 2'h1;
  localparam logic [1:0] CET_SZ_LONG = 2'h2;

  // Move addressing classes; PC-relative forms use the An-relative class
  typedef enum logic [1:0] {
    CET_EA_REG = 2'h0,
    CET_EA_MEM = 2'h1,
    CET_EA_IDX = 2'h2,
    CET_EA_IMM = 2'h3
  } cet_ea_t;

  typedef enum logic [2:0] {
    CET_ST_RSP = 3'b000,
    CET_ST_RPC = 3'b001,
    CET_ST_RUN = 3'b011,
    CET_ST_IACK = 3'b010,
    CET_ST_HALT = 3'b110
  } cet_state_t;

  // Timing answer: C(r/w)
  typedef struct packed {
    logic [3:0] cyc;
    logic [1:0] rd;
    logic [1:0] wr;
  } cet_time_t;

  // Whole controller state
  typedef struct packed {
    cet_state_t st;
    logic [15:0] sw;
    logic [31:0] vector_base_reg;
    logic mctl;
    logic [31:0] sp;
    logic [31:0] pc;
    logic [7:0] vec;
    logic [31:0] vaddr;
    logic take;
    logic in_exc;
    logic pre_first;
    logic [1:0] busy;
    logic [31:0] rdata;
    cet_time_t mv;
    cet_time_t mis;
    logic [1:0] nacc;
  } cet_state_s_t;
endpackage : cet_pkg

// ===== cet_core_ctl.sv
// Core exception sequencer, store stall and instruction timing logic
// Overview of operation
// RQ1: A software trap instruction always enters exception processing.
// RQ2: Interrupts are recognised, then the device's 8-bit vector is fetched.
// RQ3: Any fault during another fault's exception halts the core until reset.
// RQ4: Reset raises vector zero, top priority, aborting all work.
// RQ5: Reset sets supervisor, clears trace and M bit, mask to seven.
// RQ6: Reset clears vector base and disables attached memory control.
// RQ7: After bus grant, read stack pointer at 0, program counter at 4.
// RQ8: Access or address error before first instruction halts the core.
// RQ9: Cycle counts include operand traffic; read-modify-write is one each.
// RQ10: Stores keep resources busy two clocks; next store stalls.
// RQ11: Multiple-register moves skip the consecutive store stall.
// RQ12: Misaligned word or long operands split into aligned accesses.
// RQ13: Odd word: two bytes, read 2(1/0), write 1(0/1) extra.
// RQ14: Odd long: byte, word, byte; read 3(2/0), write 2(0/2).
// RQ15: Long at address 10: two words; read 2(1/0), write 1(0/1).
// RQ16: PC-relative modes cost the same as An-relative modes.
// RQ17: Byte and word move cycle counts per source and destination.
// RQ18: Longword move cycle counts per source and destination.
// RQ19: Bus error termination raises access error vector two.
// RQ20: Halted core issues no bus cycles and ignores interrupts.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module cet_core_ctl (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic bus_grant_i,
  input wire logic bus_ext_busy_i,
  input wire logic bus_ack_i,
  input wire logic bus_err_i,
  input wire logic [31:0] bus_rdata_i,
  output logic bus_req_o,
  output logic bus_iack_o,
  output logic [31:0] bus_addr_o,
  input wire logic [2:0] irq_lvl_i,
  input wire logic ex_trap_i,
  input wire logic [3:0] ex_trap_num_i,
  input wire logic ex_acc_err_i,
  input wire logic ex_addr_err_i,
  input wire logic ex_exc_done_i,
  input wire logic ex_first_done_i,
  input wire logic ex_store_i,
  input wire logic ex_multi_i,
  output logic ex_stall_o,
  input wire logic mv_valid_i,
  input wire logic mv_long_i,
  input wire cet_pkg::cet_ea_t mv_src_i,
  input wire cet_pkg::cet_ea_t mv_dst_i,
  input wire logic op_valid_i,
  input wire logic [1:0] op_addr_i,
  input wire logic [1:0] op_size_i,
  input wire logic op_write_i,
  output cet_pkg::cet_time_t mv_time_o,
  output cet_pkg::cet_time_t mis_time_o,
  output logic [1:0] mis_accesses_o,
  output logic exc_take_o,
  output logic [7:0] exc_vec_o,
  output logic [31:0] exc_addr_o,
  output logic [15:0] status_word_o,
  output logic [31:0] vector_base_reg_o,
  output logic mem_enable_o,
  output logic [31:0] sp_o,
  output logic [31:0] pc_o,
  output logic halted_o
);
  import cet_pkg::*;

  cet_state_s_t r;
  cet_state_s_t next_r;
  logic irq_pend;
  logic fault;
  logic stall;
  logic [7:0] trap_vec;
  logic [31:0] rd_mux;
  cet_time_t mv_t;
  cet_time_t mis_t;
  logic [1:0] mis_n;
  logic [3:0] mv_base;

  // Interrupt is pending above the mask; level seven cannot be masked
  assign irq_pend = (irq_lvl_i > r.sw[CET_SW_MASK_LO +: 3]) ||
                    (irq_lvl_i == CET_MASK_TOP);
  assign fault = ex_acc_err_i || ex_addr_err_i;
  assign trap_vec = CET_VEC_TRAP + {4'h0, ex_trap_num_i};
  // A new store waits while the previous store's resources are busy
  assign stall = ex_store_i && !ex_multi_i && (r.busy != 2'h0); // RQ10 RQ11

  // Move timing; memory source costs three for byte/word, two for long
  always_comb begin
    mv_base = mv_long_i ? 4'h2 : 4'h3; // RQ17 RQ18
    mv_t = '{cyc: 4'h1, rd: 2'h0, wr: 2'h0};
    unique case (mv_src_i) // RQ16
      CET_EA_REG: begin
        mv_t.cyc = (mv_dst_i == CET_EA_IDX) ? 4'h2 : 4'h1;
      end
      CET_EA_MEM: begin
        mv_t.cyc = mv_base + ((mv_dst_i == CET_EA_IDX) ? 4'h1 : 4'h0);
        mv_t.rd = 2'h1;
      end
      CET_EA_IDX: begin
        mv_t.cyc = mv_base + 4'h1;
        mv_t.rd = 2'h1;
      end
      CET_EA_IMM: begin
        mv_t.cyc = (mv_dst_i == CET_EA_REG) ? 4'h1 : mv_base;
      end
    endcase
    // Each memory destination is one operand write; RMW counts (1/1)
    if (mv_dst_i != CET_EA_REG) begin
      mv_t.wr = 2'h1; // RQ9
    end
  end

  // Misaligned operand decomposition into aligned pieces
  always_comb begin
    mis_t = '{cyc: 4'h0, rd: 2'h0, wr: 2'h0};
    mis_n = 2'h1;
    if (op_size_i == CET_SZ_WORD && op_addr_i[0]) begin
      mis_n = 2'h2; // RQ12 RQ13
      mis_t.cyc = op_write_i ? 4'h1 : 4'h2;
      mis_t.rd = op_write_i ? 2'h0 : 2'h1;
      mis_t.wr = op_write_i ? 2'h1 : 2'h0;
    end else if (op_size_i == CET_SZ_LONG && op_addr_i[0]) begin
      mis_n = 2'h3; // RQ12 RQ14
      mis_t.cyc = op_write_i ? 4'h2 : 4'h3;
      mis_t.rd = op_write_i ? 2'h0 : 2'h2;
      mis_t.wr = op_write_i ? 2'h2 : 2'h0;
    end else if (op_size_i == CET_SZ_LONG && op_addr_i == 2'h2) begin
      mis_n = 2'h2; // RQ12 RQ15
      mis_t.cyc = op_write_i ? 4'h1 : 4'h2;
      mis_t.rd = op_write_i ? 2'h0 : 2'h1;
      mis_t.wr = op_write_i ? 2'h1 : 2'h0;
    end
  end

  // Register read mux; unmapped offsets read as zero
  always_comb begin
    unique case (reg_addr_i)
      CET_OFS_SW: rd_mux = {16'h0, r.sw};
      CET_OFS_VBR: rd_mux = r.vector_base_reg;
      CET_OFS_MCTL: rd_mux = {31'h0, r.mctl};
      CET_OFS_STATE: rd_mux = {16'h0, r.vec, 2'h0, r.pre_first,
                               r.in_exc, r.st == CET_ST_HALT, r.st};
      CET_OFS_SP: rd_mux = r.sp;
      CET_OFS_PC: rd_mux = r.pc;
      default: rd_mux = 32'h0;
    endcase
  end

  // Next-state logic for the whole controller
  always_comb begin
    next_r = r;
    next_r.take = 1'b0;
    next_r.rdata = reg_rd_i ? rd_mux : 32'h0;
    next_r.busy = (r.busy != 2'h0) ? r.busy - 2'h1 : 2'h0;
    // The busy window starts after the store's last data cycle
    if (ex_store_i && !ex_multi_i && !stall) begin
      next_r.busy = CET_STORE_BUSY; // RQ10
    end
    if (mv_valid_i) begin
      next_r.mv = mv_t;
    end
    if (op_valid_i) begin
      next_r.mis = mis_t;
      next_r.nacc = mis_n;
    end
    if (reg_wr_i && r.st != CET_ST_HALT) begin
      unique case (reg_addr_i)
        CET_OFS_SW: next_r.sw = reg_wdata_i[15:0];
        CET_OFS_VBR: next_r.vector_base_reg = reg_wdata_i;
        CET_OFS_MCTL: next_r.mctl = reg_wdata_i[0];
        default: ;
      endcase
    end
    if (ex_first_done_i) begin
      next_r.pre_first = 1'b0;
    end
    if (ex_exc_done_i) begin
      next_r.in_exc = 1'b0;
    end
    unique case (r.st)
      CET_ST_RSP, CET_ST_RPC: begin
        // Reset fetch of stack pointer then program counter
        if (bus_err_i) begin
          next_r.st = CET_ST_HALT; // RQ8
        end else if (bus_ack_i && r.st == CET_ST_RSP) begin
          next_r.sp = bus_rdata_i; // RQ7
          next_r.st = CET_ST_RPC;
          next_r.vaddr = CET_ADR_PC;
        end else if (bus_ack_i) begin
          next_r.pc = bus_rdata_i; // RQ7
          next_r.st = CET_ST_RUN;
        end
      end
      CET_ST_RUN: begin
        // Faults beat traps, traps beat interrupts
        if (fault && (r.in_exc || r.pre_first)) begin
          next_r.st = CET_ST_HALT; // RQ3 RQ8
        end else if (fault) begin
          next_r.vec = ex_acc_err_i ? CET_VEC_ACC : CET_VEC_ADR; // RQ19
          next_r.take = 1'b1;
          next_r.in_exc = 1'b1;
        end else if (ex_trap_i) begin
          next_r.vec = trap_vec; // RQ1
          next_r.take = 1'b1;
          next_r.in_exc = 1'b1;
        end else if (irq_pend && !r.in_exc && !r.pre_first) begin
          next_r.st = CET_ST_IACK; // RQ2
          next_r.vaddr = {29'h0, irq_lvl_i};
        end
      end
      CET_ST_IACK: begin
        // Device supplies the vector; an error answer is spurious
        if (bus_ack_i || bus_err_i) begin
          next_r.vec = bus_err_i ? CET_VEC_SPUR : bus_rdata_i[7:0]; // RQ2
          next_r.sw[CET_SW_MASK_LO +: 3] = r.vaddr[2:0];
          next_r.take = 1'b1;
          next_r.in_exc = 1'b1;
          next_r.st = CET_ST_RUN;
        end else if (fault) begin
          next_r.st = CET_ST_HALT; // RQ3
        end
      end
      CET_ST_HALT: begin
        next_r.st = CET_ST_HALT; // RQ3 RQ20
      end
      default: next_r.st = CET_ST_HALT;
    endcase
    if (next_r.take) begin
      next_r.sw[CET_SW_S] = 1'b1;
      next_r.sw[CET_SW_T] = 1'b0;
    end
    // Reset overrides everything and is the only way out of a halt
    if (sys_rst_i) begin
      next_r = '0; // RQ4
      next_r.st = CET_ST_RSP;
      next_r.vec = CET_VEC_RST; // RQ4
      next_r.sw = CET_SW_RST; // RQ5
      next_r.vector_base_reg = CET_VBR_RST; // RQ6
      next_r.mctl = 1'b0; // RQ6
      next_r.vaddr = CET_ADR_SP; // RQ7
      next_r.pre_first = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge clk_i) begin
    r <= next_r;
  end

  // Bus request only once granted and no other master is active
  assign bus_req_o = (r.st == CET_ST_RSP || r.st == CET_ST_RPC ||
                      r.st == CET_ST_IACK) && bus_grant_i &&
                     !bus_ext_busy_i; // RQ7 RQ20
  assign bus_iack_o = (r.st == CET_ST_IACK) && bus_grant_i &&
                      !bus_ext_busy_i;
  assign bus_addr_o = r.vaddr;
  assign ex_stall_o = stall;
  assign reg_rdata_o = r.rdata;
  assign mv_time_o = r.mv;
  assign mis_time_o = r.mis;
  assign mis_accesses_o = r.nacc;
  assign exc_take_o = r.take;
  assign exc_vec_o = r.vec;
  assign exc_addr_o = r.vector_base_reg + {22'h0, r.vec, 2'h0};
  assign status_word_o = r.sw;
  assign vector_base_reg_o = r.vector_base_reg;
  assign mem_enable_o = r.mctl;
  assign sp_o = r.sp;
  assign pc_o = r.pc;
  assign halted_o = (r.st == CET_ST_HALT);

  // Checks next to the logic
  a_trap_enters: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ex_trap_i && !fault && r.st == CET_ST_RUN |=> exc_take_o &&
    exc_vec_o == $past(trap_vec)) else $error("trap not taken"); // RQ1
  a_iack_vector: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    r.st == CET_ST_IACK && bus_ack_i && !bus_err_i |=> exc_take_o &&
    exc_vec_o == $past(bus_rdata_i[7:0])) else $error("bad iack vec"); // RQ2
  a_halt_sticks: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    halted_o |=> halted_o && !bus_req_o && !exc_take_o)
    else $error("halt left"); // RQ3
  a_reset_values: assert property (@(posedge clk_i)
    sys_rst_i |=> status_word_o == CET_SW_RST && vector_base_reg_o == 32'h0
    && !mem_enable_o && exc_vec_o == CET_VEC_RST)
    else $error("reset values wrong"); // RQ5
  a_reset_fetch: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    r.st == CET_ST_RSP && bus_ack_i && !bus_err_i |=> r.st == CET_ST_RPC &&
    bus_addr_o == CET_ADR_PC && sp_o == $past(bus_rdata_i))
    else $error("sp fetch wrong"); // RQ7
  a_early_fault: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    r.st == CET_ST_RUN && r.pre_first && fault |=> halted_o)
    else $error("early fault not halted"); // RQ8
  a_store_window: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ex_store_i && !ex_multi_i && !stall ##1 ex_store_i && !ex_multi_i
    |-> ex_stall_o) else $error("store not stalled"); // RQ10
  a_multi_free: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ex_multi_i |-> !ex_stall_o) else $error("multi move stalled"); // RQ11
  a_odd_long: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_valid_i && op_size_i == CET_SZ_LONG && op_addr_i[0] && !op_write_i
    |=> mis_time_o.cyc == 4'h3 && mis_time_o.rd == 2'h2 &&
    mis_accesses_o == 2'h3) else $error("odd long split wrong"); // RQ14
  a_move_long: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mv_valid_i && mv_long_i && mv_src_i == CET_EA_MEM &&
    mv_dst_i == CET_EA_MEM |=> mv_time_o.cyc == 4'h2 && mv_time_o.rd == 2'h1
    && mv_time_o.wr == 2'h1) else $error("long move time wrong"); // RQ18
  a_acc_vector: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    r.st == CET_ST_RUN && ex_acc_err_i && !r.in_exc && !r.pre_first
    |=> exc_vec_o == CET_VEC_ACC && exc_take_o)
    else $error("access error vector"); // RQ19
  // Fault paths into the halted state, both during fetch and in exceptions
  a_fetch_error: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (r.st == CET_ST_RSP || r.st == CET_ST_RPC) && bus_err_i |=> halted_o)
    else $error("fetch error not halted"); // RQ8
  a_fault_halt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    r.st == CET_ST_RUN && fault && r.in_exc |=> halted_o)
    else $error("fault on fault not halted"); // RQ3
  // Split figures for the other misaligned shapes, then the short move time
  a_odd_word: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_valid_i && op_size_i == CET_SZ_WORD && op_addr_i[0] && op_write_i
    |=> mis_time_o.cyc == 4'h1 && mis_time_o.wr == 2'h1 &&
    mis_time_o.rd == 2'h0 && mis_accesses_o == 2'h2)
    else $error("odd word split wrong"); // RQ13
  a_long_halves: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_valid_i && op_size_i == CET_SZ_LONG && op_addr_i == 2'h2 &&
    !op_write_i |=> mis_time_o.cyc == 4'h2 && mis_time_o.rd == 2'h1 &&
    mis_accesses_o == 2'h2) else $error("long halves wrong"); // RQ15
  a_move_short: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mv_valid_i && !mv_long_i && mv_src_i == CET_EA_MEM &&
    mv_dst_i == CET_EA_REG |=> mv_time_o.cyc == 4'h3 &&
    mv_time_o.rd == 2'h1 && mv_time_o.wr == 2'h0)
    else $error("short move time wrong"); // RQ17
  // Read data must not linger, a read without a strobe returns zero; iack only with a bus request
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !reg_rd_i |=> reg_rdata_o == 32'h0) else $error("read data lingers");
  a_iack_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bus_iack_o |-> bus_req_o) else $error("iack without request"); // RQ2
  // Reset must drop a halt and any pending entry
  a_reset_clear: assert property (@(posedge clk_i)
    sys_rst_i |=> !halted_o && !exc_take_o && !bus_iack_o)
    else $error("reset left state"); // RQ4
endmodule : cet_core_ctl

// ===== cet_bus_model.sv
// Behavioural system bus memory and interrupting device for the controller
`timescale 1ns/1ps
module cet_bus_model #(
  parameter logic [31:0] SP_V = 32'h0000_8000,
  parameter logic [31:0] PC_V = 32'h0000_0400
) (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic iack_i,
  input wire logic [31:0] addr_i,
  input wire logic err_en_i,
  input wire logic [1:0] dly_i,
  input wire logic [7:0] vec_i,
  output logic ack_o,
  output logic err_o,
  output logic [31:0] rdata_o
);
  logic [1:0] cnt = 2'h0;
  logic busy;
  initial begin
    ack_o = 1'b0;
    err_o = 1'b0;
    rdata_o = 32'h5a5a_a5a5;
  end
  assign busy = (req_i || iack_i) && !ack_o && !err_o;
  // Ends a cycle after dly_i waits; data scrambles outside the answer
  // so that a stale sample cannot pass for a real one
  always @(posedge clk_i) begin
    if (busy && cnt == dly_i) begin
      cnt <= 2'h0;
      ack_o <= !err_en_i;
      err_o <= err_en_i;
      if (iack_i) begin
        rdata_o <= {24'h0, vec_i};
      end else begin
        rdata_o <= (addr_i == 32'h0) ? SP_V : PC_V;
      end
    end else begin
      cnt <= busy ? cnt + 2'h1 : 2'h0;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule : cet_bus_model

// ===== tb_top.sv
// Self-checking bench for the core exception and timing controller
`timescale 1ns/1ps
module tb_top;
  import cet_pkg::*;
  typedef struct packed {
    logic lng;
    cet_ea_t src;
    cet_ea_t dst;
    logic [7:0] mv;
    logic [1:0] adr;
    logic [1:0] sz;
    logic wr;
    logic [7:0] mis;
    logic [1:0] acc;
  } cet_row_t;
  localparam logic [31:0] SP_V = 32'h0000_8000;
  localparam logic [31:0] PC_V = 32'h0000_0400;
  // Move class and operand placement, then C(r/w) packed as {c,r,w}
  cet_row_t rows [12] = '{
    '{1'b0, CET_EA_REG, CET_EA_REG, 8'h10, 2'h1, CET_SZ_WORD, 1'b0, 8'h24, 2'h2},
    '{1'b0, CET_EA_REG, CET_EA_IDX, 8'h21, 2'h3, CET_SZ_WORD, 1'b1, 8'h11, 2'h2},
    '{1'b0, CET_EA_MEM, CET_EA_REG, 8'h34, 2'h1, CET_SZ_LONG, 1'b0, 8'h38, 2'h3},
    '{1'b0, CET_EA_IDX, CET_EA_REG, 8'h44, 2'h3, CET_SZ_LONG, 1'b1, 8'h22, 2'h3},
    '{1'b0, CET_EA_MEM, CET_EA_MEM, 8'h35, 2'h2, CET_SZ_LONG, 1'b0, 8'h24, 2'h2},
    '{1'b0, CET_EA_IMM, CET_EA_MEM, 8'h31, 2'h2, CET_SZ_LONG, 1'b1, 8'h11, 2'h2},
    '{1'b1, CET_EA_REG, CET_EA_REG, 8'h10, 2'h0, CET_SZ_LONG, 1'b0, 8'h00, 2'h1},
    '{1'b1, CET_EA_MEM, CET_EA_REG, 8'h24, 2'h2, CET_SZ_WORD, 1'b1, 8'h00, 2'h1},
    '{1'b1, CET_EA_IDX, CET_EA_REG, 8'h34, 2'h3, CET_SZ_BYTE, 1'b0, 8'h00, 2'h1},
    '{1'b1, CET_EA_MEM, CET_EA_MEM, 8'h25, 2'h0, CET_SZ_WORD, 1'b0, 8'h00, 2'h1},
    '{1'b1, CET_EA_IMM, CET_EA_MEM, 8'h21, 2'h0, CET_SZ_LONG, 1'b1, 8'h00, 2'h1},
    '{1'b1, CET_EA_MEM, CET_EA_IDX, 8'h35, 2'h1, CET_SZ_BYTE, 1'b1, 8'h00, 2'h1}
  };
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ebusy = 1'b1;
  logic [2:0] irq = 3'h0;
  logic [4:0] ex = 5'h0;
  logic st = 1'b0;
  logic multi = 1'b0;
  logic vld = 1'b0;
  logic err_en = 1'b0;
  logic [1:0] dly = 2'h1;
  logic [7:0] pvec = 8'h00;
  cet_row_t r = '0;
  logic ack, berr, req, iack, stall, take, halted, men;
  logic [31:0] brd, baddr, rdata, eaddr, vector_base_reg, sp, pc;
  logic [15:0] sw;
  logic [7:0] vec;
  logic [1:0] macc;
  cet_time_t mvt, mist;
  int errors = 0;
  int comparisons = 0;

  always #50 clk_i = ~clk_i;

  cet_core_ctl dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .bus_grant_i(1'b1),
    .bus_ext_busy_i(ebusy), .bus_ack_i(ack), .bus_err_i(berr),
    .bus_rdata_i(brd), .bus_req_o(req), .bus_iack_o(iack),
    .bus_addr_o(baddr), .irq_lvl_i(irq), .ex_trap_i(ex[0]),
    .ex_trap_num_i(4'h5), .ex_acc_err_i(ex[1]), .ex_addr_err_i(ex[2]),
    .ex_exc_done_i(ex[3]), .ex_first_done_i(ex[4]), .ex_store_i(st),
    .ex_multi_i(multi), .ex_stall_o(stall), .mv_valid_i(vld),
    .mv_long_i(r.lng), .mv_src_i(r.src), .mv_dst_i(r.dst),
    .op_valid_i(vld), .op_addr_i(r.adr), .op_size_i(r.sz),
    .op_write_i(r.wr), .mv_time_o(mvt), .mis_time_o(mist),
    .mis_accesses_o(macc), .exc_take_o(take), .exc_vec_o(vec),
    .exc_addr_o(eaddr), .status_word_o(sw), .vector_base_reg_o(vector_base_reg),
    .mem_enable_o(men), .sp_o(sp), .pc_o(pc), .halted_o(halted)
  );

  cet_bus_model #(.SP_V(SP_V), .PC_V(PC_V)) bus_u (
    .clk_i(clk_i), .req_i(req), .iack_i(iack), .addr_i(baddr),
    .err_en_i(err_en), .dly_i(dly), .vec_i(pvec), .ack_o(ack),
    .err_o(berr), .rdata_o(brd)
  );

  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic sig(input int s);
    case (s)
      0: return take;
      1: return halted;
      default: return pc === PC_V;
    endcase
  endfunction : sig

  // Bounded wait; running out ends the run as a mismatch
  task automatic wait_hi(input int s);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (sig(s) !== 1'b1 && n < 12);
    if (sig(s) !== 1'b1) begin
      errors++;
      $display("[ERR] wait %0d exp 1 seen 0", s);
      tally_and_finish();
    end
  endtask : wait_hi

  task automatic do_reset(input logic e);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    err_en <= e;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask : do_reset

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : reg_wr

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    check("reg_rdata", rdata, exp);
  endtask : reg_rd

  task automatic pulse(input int s);
    @(posedge clk_i);
    ex <= 5'h1 << s;
    @(posedge clk_i);
    ex <= 5'h0;
  endtask : pulse

  task automatic exc(input int s, input logic [7:0] v);
    pulse(s);
    wait_hi(0);
    check("exc_vec", {24'h0, vec}, {24'h0, v});
    check("exc_addr", eaddr, 32'h1000 + {22'h0, v, 2'b00});
    pulse(3);
  endtask : exc

  task automatic irq_case(input logic [2:0] l, input logic e,
                          input logic [7:0] v);
    @(posedge clk_i);
    err_en <= e;
    pvec <= v;
    irq <= l;
    wait_hi(0);
    check("irq_vec", {24'h0, vec}, {24'h0, e ? CET_VEC_SPUR : v});
    check("mask", {29'h0, sw[10:8]}, {29'h0, l});
    check("iack_addr", baddr, {29'h0, l});
    @(posedge clk_i);
    irq <= 3'h0;
    err_en <= 1'b0;
    pulse(3);
  endtask : irq_case

  // Main sequence: reset, fetch, registers, rows, then the awkward cases
  initial begin
    do_reset(1'b0);
    repeat (3) begin
      @(negedge clk_i);
      check("bus_req", {31'h0, req}, 32'h0);
    end
    @(posedge clk_i);
    ebusy <= 1'b0;
    check("status", {16'h0, sw}, {16'h0, CET_SW_RST});
    check("vbr", vector_base_reg, CET_VBR_RST);
    check("mem_en", {31'h0, men}, 32'h0);
    wait_hi(2);
    check("sp", sp, SP_V);
    reg_rd(CET_OFS_SP, SP_V);
    reg_rd(CET_OFS_PC, PC_V);
    reg_rd(CET_OFS_STATE, 32'h0000_0023);
    reg_rd(CET_OFS_SW, 32'h0000_2700);
    reg_rd(CET_OFS_MCTL, 32'h0);
    reg_wr(CET_OFS_VBR, 32'h0000_1000);
    reg_wr(CET_OFS_MCTL, 32'h1);
    reg_rd(CET_OFS_VBR, 32'h0000_1000);
    reg_rd(8'h20, 32'h0);
    check("mem_en", {31'h0, men}, 32'h1);
    foreach (rows[i]) begin
      @(posedge clk_i);
      r <= rows[i];
      vld <= 1'b1;
      @(posedge clk_i);
      vld <= 1'b0;
      @(negedge clk_i);
      check("mv_time", {24'h0, mvt}, {24'h0, rows[i].mv});
      check("mis_time", {24'h0, mist}, {24'h0, rows[i].mis});
      check("mis_acc", {30'h0, macc}, {30'h0, rows[i].acc});
    end
    // Stores back to back, the last one a multi-register move
    @(posedge clk_i);
    st <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_i);
      check("stall", {31'h0, stall}, {31'h0, i == 1 || i == 2});
      @(posedge clk_i);
      multi <= (i == 3);
      st <= (i < 4);
    end
    multi <= 1'b0;
    pulse(4);
    exc(0, 8'h25);
    exc(1, CET_VEC_ACC);
    exc(2, CET_VEC_ADR);
    reg_wr(CET_OFS_SW, 32'h0000_2000);
    dly <= 2'h0;
    irq_case(3'h3, 1'b0, 8'h40);
    irq_case(3'h5, 1'b1, 8'h00);
    irq_case(3'h7, 1'b0, 8'h0f);
    // Fault inside a trap's exception must halt for good
    pulse(0);
    wait_hi(0);
    pulse(1);
    wait_hi(1);
    @(posedge clk_i);
    irq <= 3'h7;
    repeat (6) begin
      @(negedge clk_i);
      check("halt_bus", {29'h0, req, iack, take}, 32'h0);
    end
    @(posedge clk_i);
    irq <= 3'h0;
    reg_wr(CET_OFS_VBR, 32'h0000_2000);
    reg_rd(CET_OFS_VBR, 32'h0000_1000);
    do_reset(1'b1);
    @(negedge clk_i);
    check("halted", {31'h0, halted}, 32'h0);
    check("status", {16'h0, sw}, {16'h0, CET_SW_RST});
    wait_hi(1);
    do_reset(1'b0);
    wait_hi(2);
    pulse(2);
    wait_hi(1);
    tally_and_finish();
  end
endmodule : tb_top
